// ### parallel_port_handshake_irq.sv
// Two-port handshake parallel port with daisy-chain vectored interrupts
// Overview of operation
// - Port select low picks A, high B
// - Control select high means command, low data
// - Chip select, read, request drive read data
// - Chip select and request without read writes
// - Priority out high only if in high, idle
// - Cycle-one alone for two cycles resets the whole block
// - Output mode write latches data, raises ready
// - Ready holds until strobe rise; rise interrupts
// - Input mode loads pins while strobe low
// - Input strobe rise interrupts and drops ready together
// - Read completion re-raises ready next cycle
// - Bidirectional: A pair outputs, B pair inputs
// - Bidirectional A pins driven only strobe low
// - B ready shows A input empty; B strobe loads
// - Bit mode: no handshake, writes any time
// - Bit read mixes outputs and pre-read inputs
// - Bit mode mask logic interrupts; B silenced when A bidir
// - Acknowledge keeps enables; chain winner gives vector
// - Serviced port blocks chain until return opcode
// - Prefix opens chain; return byte ends service
// - Control word picks AND/OR and level
// - Vector bit zero forced to zero
// - Interrupts armed only after cycle-one low

// -------------------------------------------------
// Output data buffer
// -------------------------------------------------
module parallel_port_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;
    assign in_ready_o = count != (PW+1)'(DEPTH);
    assign out_valid_o = count != '0;
    assign out_data_o = mem[rd_ptr];

    // Depth is a power of two, so pointers wrap naturally
    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            case ({push, pop})
                2'b10: count <= count + 1'b1;
                2'b01: count <= count - 1'b1;
                default: count <= count;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (push) mem[wr_ptr] <= in_data_i;
    end
endmodule : parallel_port_fifo

// -------------------------------------------------
// Port controller
// -------------------------------------------------
module parallel_port_handshake_irq (
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    input wire parallel_port_pkg::cpu_ctl_t cpu_ctl_i,
    input wire logic [7:0] cpu_data_i,
    output logic [7:0] cpu_data_o,
    output logic cpu_data_oe_o,
    output logic cpu_write_ready_o,
    input wire logic priority_in_i,
    output logic priority_out_o,
    input wire logic irq_n_i,
    output logic irq_n_o,
    output logic irq_oe_o,
    input wire logic [7:0] port_a_i,
    output logic [7:0] port_a_o,
    output logic [7:0] port_a_oe_o,
    input wire logic port_a_strobe_n_i,
    output logic port_a_ready_o,
    input wire logic [7:0] port_b_i,
    output logic [7:0] port_b_o,
    output logic [7:0] port_b_oe_o,
    input wire logic port_b_strobe_n_i,
    output logic port_b_ready_o
);
    import parallel_port_pkg::*;

    port_cfg_t cfg [2];
    logic [7:0] out_reg [2];
    logic [7:0] in_reg [2];
    logic [7:0] pins [2];
    logic [7:0] act [2];
    logic [7:0] cons [2];
    logic [1:0] stb_n, stb_q, stb_rise, rdy, pend, srv, armed;
    logic [1:0] role_in, role_out, role_in_q, ev, match, match_q;
    logic [1:0] cmd_wr, data_wr, load_out, rd_hit, int_ok;
    logic bus_act, bus_q, wr_take, rd_act, rd_q, rd_port, rd_end;
    logic ack_act, ack_q, ack_start, ack_hold, grant, grant_b;
    logic fetch, fetch_q, ed_seen, m1_alone, m1_q, rst, a_bidir;
    logic [7:0] fetch_data, fifo_data, rd_data;
    logic fifo_valid, fifo_in_ready, fifo_pop;

    // -------------------------------------------------
    // CPU cycle decode
    // -------------------------------------------------
    assign m1_alone = !cpu_ctl_i.cycle_one_n && cpu_ctl_i.read_strobe_n
                      && cpu_ctl_i.io_request_n;
    assign rst = !reset_n_i || (m1_alone && m1_q);
    assign bus_act = !cpu_ctl_i.chip_select_n && !cpu_ctl_i.io_request_n
                     && cpu_ctl_i.cycle_one_n;
    assign wr_take = bus_act && !bus_q && cpu_ctl_i.read_strobe_n;
    assign rd_act = bus_act && !cpu_ctl_i.read_strobe_n;
    assign rd_end = rd_q && !rd_act;
    assign ack_act = !cpu_ctl_i.cycle_one_n && !cpu_ctl_i.io_request_n;
    assign ack_start = ack_act && !ack_q;
    assign fetch = !cpu_ctl_i.cycle_one_n && !cpu_ctl_i.read_strobe_n
                   && cpu_ctl_i.io_request_n;
    assign a_bidir = cfg[0].mode == MODE_BIDIR;
    assign stb_n = {port_b_strobe_n_i, port_a_strobe_n_i};
    assign stb_rise = stb_n & ~stb_q;
    assign pins[0] = port_a_i;
    assign pins[1] = port_b_i;
    assign fifo_pop = fifo_valid && role_out[0] && !rdy[0];
    assign grant = priority_in_i && !(|srv) && (|pend);
    assign grant_b = !pend[0];
    assign port_a_o = out_reg[0];
    assign port_b_o = out_reg[1];
    assign port_a_ready_o = rdy[0];
    assign port_b_ready_o = rdy[1];

    always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) m1_q <= 1'b0;
        else m1_q <= m1_alone;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst) begin
            bus_q <= 1'b0;
            rd_q <= 1'b0;
            rd_port <= 1'b0;
            ack_q <= 1'b0;
            fetch_q <= 1'b0;
            fetch_data <= 8'h00;
        end else begin
            bus_q <= bus_act;
            rd_q <= rd_act && !cpu_ctl_i.control_data_select;
            if (rd_act) rd_port <= cpu_ctl_i.port_select;
            ack_q <= ack_act;
            fetch_q <= fetch;
            if (fetch) fetch_data <= cpu_data_i;
        end
    end

    // -------------------------------------------------
    // Per-port roles and events
    // -------------------------------------------------
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            cmd_wr[p] = wr_take && cpu_ctl_i.control_data_select
                        && (cpu_ctl_i.port_select == 1'(p));
            data_wr[p] = wr_take && !cpu_ctl_i.control_data_select
                         && (cpu_ctl_i.port_select == 1'(p));
            act[p] = cfg[p].active_high ? pins[p] : ~pins[p];
            cons[p] = cfg[p].io_dir & ~cfg[p].mask;
            match[p] = cfg[p].and_mode
                ? (cons[p] != 8'h00 && (act[p] & cons[p]) == cons[p])
                : |(act[p] & cons[p]);
            int_ok[p] = cfg[p].int_en && armed[p];
        end
        role_out[0] = cfg[0].mode == MODE_OUT || a_bidir;
        role_in[0] = cfg[0].mode == MODE_IN;
        role_out[1] = cfg[1].mode == MODE_OUT && !a_bidir;
        role_in[1] = (cfg[1].mode == MODE_IN && !a_bidir) || a_bidir;
        rd_hit[0] = rd_end && rd_port == 1'b0;
        rd_hit[1] = rd_end && rd_port == !a_bidir;
        load_out[0] = fifo_pop;
        load_out[1] = data_wr[1] && role_out[1];
        ev[0] = (stb_rise[0] && (role_out[0] || role_in[0]))
                || (match[0] && !match_q[0] && cfg[0].mode == MODE_BIT);
        ev[1] = (stb_rise[1] && (role_out[1] || role_in[1]))
                || (match[1] && !match_q[1] && cfg[1].mode == MODE_BIT
                    && !a_bidir);
    end

    // -------------------------------------------------
    // Configuration words
    // -------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (rst) begin
                cfg[p] <= CFG_RESET;
            end else if (cmd_wr[p]) begin
                case (cfg[p].next_word)
                    NEXT_DIR: begin
                        cfg[p].io_dir <= cpu_data_i;
                        cfg[p].next_word <= NEXT_CMD;
                    end
                    NEXT_MASK: begin
                        cfg[p].mask <= cpu_data_i;
                        cfg[p].next_word <= NEXT_CMD;
                    end
                    default: begin
                        if (!cpu_data_i[0]) begin
                            cfg[p].vector <= {cpu_data_i[7:1], 1'b0};
                        end else if (cpu_data_i[3:0] == CW_MODE) begin
                            cfg[p].mode <= port_mode_t'(cpu_data_i[7:6]);
                            cfg[p].next_word <= (cpu_data_i[7:6] == MODE_BIT)
                                ? NEXT_DIR : NEXT_CMD;
                        end else if (cpu_data_i[3:0] == CW_INT_CTRL) begin
                            cfg[p].int_en <= cpu_data_i[CW_IE_BIT];
                            cfg[p].and_mode <= cpu_data_i[CW_AND_BIT];
                            cfg[p].active_high <= cpu_data_i[CW_HIGH_BIT];
                            cfg[p].next_word <= cpu_data_i[CW_MASK_BIT]
                                ? NEXT_MASK : NEXT_CMD;
                        end else if (cpu_data_i[3:0] == CW_INT_EN) begin
                            cfg[p].int_en <= cpu_data_i[CW_IE_BIT];
                        end
                    end
                endcase
            end
        end
    end

    // Any command disarms the port until the next cycle-one low
    always_ff @(posedge sys_clk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (rst) armed[p] <= 1'b0;
            else if (cmd_wr[p]) armed[p] <= 1'b0;
            else if (!cpu_ctl_i.cycle_one_n) armed[p] <= 1'b1;
        end
    end

    // -------------------------------------------------
    // Port A output buffer; CPU must respect write ready
    // -------------------------------------------------
    parallel_port_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) a_fifo (
        .sys_clk_i(sys_clk_i),
        .reset_n_i(!rst),
        .in_valid_i(data_wr[0] && role_out[0]),
        .in_ready_o(fifo_in_ready),
        .in_data_i(cpu_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    always_ff @(posedge sys_clk_i) begin
        if (rst) cpu_write_ready_o <= 1'b0;
        else cpu_write_ready_o <= fifo_in_ready;
    end

    // -------------------------------------------------
    // Data registers and pin drive
    // -------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (rst) begin
            out_reg[0] <= 8'h00;
            out_reg[1] <= 8'h00;
        end else begin
            if (fifo_pop) out_reg[0] <= fifo_data;
            else if (data_wr[0] && !role_out[0]) out_reg[0] <= cpu_data_i;
            if (data_wr[1]) out_reg[1] <= cpu_data_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (rst) begin
                in_reg[p] <= 8'h00;
            end else if (cfg[p].mode == MODE_BIT && !(p == 1 && a_bidir)) begin
                if (cpu_ctl_i.read_strobe_n) in_reg[p] <= pins[p];
            end
        end
        if (!rst) begin
            if (role_in[0] && !stb_n[0]) in_reg[0] <= pins[0];
            if (a_bidir && !stb_n[1]) in_reg[0] <= pins[0];
            else if (role_in[1] && !a_bidir && !stb_n[1])
                in_reg[1] <= pins[1];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst) begin
            port_a_oe_o <= 8'h00;
            port_b_oe_o <= 8'h00;
        end else begin
            case (cfg[0].mode)
                MODE_OUT: port_a_oe_o <= 8'hFF;
                MODE_BIDIR: port_a_oe_o <= {8{!port_a_strobe_n_i}};
                MODE_BIT: port_a_oe_o <= ~cfg[0].io_dir;
                default: port_a_oe_o <= 8'h00;
            endcase
            case (cfg[1].mode)
                MODE_OUT: port_b_oe_o <= 8'hFF;
                MODE_BIT: port_b_oe_o <= ~cfg[1].io_dir;
                default: port_b_oe_o <= 8'h00;
            endcase
        end
    end

    // -------------------------------------------------
    // Handshake ready
    // -------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (rst) begin
                rdy[p] <= 1'b0;
                role_in_q[p] <= 1'b0;
                stb_q[p] <= 1'b1;
                match_q[p] <= 1'b0;
            end else begin
                role_in_q[p] <= role_in[p];
                stb_q[p] <= stb_n[p];
                match_q[p] <= match[p];
                // Leaving the input role drops the stale input-empty ready
                if (role_out[p]) begin
                    if (load_out[p]) rdy[p] <= 1'b1;
                    else if (stb_rise[p] || role_in_q[p])
                        rdy[p] <= 1'b0;
                end else if (role_in[p]) begin
                    if (stb_rise[p]) rdy[p] <= 1'b0;
                    else if (rd_hit[p] || !role_in_q[p])
                        rdy[p] <= 1'b1;
                end else begin
                    rdy[p] <= 1'b0;
                end
            end
        end
    end

    // -------------------------------------------------
    // Interrupts and daisy chain
    // -------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        for (int p = 0; p < 2; p++) begin
            if (rst) begin
                pend[p] <= 1'b0;
            end else if (ev[p] && int_ok[p]) begin
                pend[p] <= 1'b1;
            end else if (ack_start && grant && grant_b == 1'(p)) begin
                pend[p] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst) begin
            srv <= 2'b00;
            ed_seen <= 1'b0;
        end else begin
            if (ack_start && grant) srv[grant_b] <= 1'b1;
            if (fetch_q && !fetch) begin
                ed_seen <= fetch_data == OPC_PREFIX;
                if (ed_seen && fetch_data == OPC_RETURN && priority_in_i) begin
                    if (srv[0]) srv[0] <= 1'b0;
                    else srv[1] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst) begin
            priority_out_o <= 1'b0;
            irq_oe_o <= 1'b0;
        end else begin
            priority_out_o <= priority_in_i && !(|srv)
                              && (!(|pend) || ed_seen);
            irq_oe_o <= priority_in_i && !(|srv) && (|pend);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst) irq_n_o <= 1'b0;
        else irq_n_o <= 1'b0;
    end

    // -------------------------------------------------
    // CPU read data and vector
    // -------------------------------------------------
    always_comb begin
        rd_data = in_reg[cpu_ctl_i.port_select];
        if (cfg[cpu_ctl_i.port_select].mode == MODE_BIT) begin
            rd_data = (out_reg[cpu_ctl_i.port_select]
                       & ~cfg[cpu_ctl_i.port_select].io_dir)
                      | (in_reg[cpu_ctl_i.port_select]
                         & cfg[cpu_ctl_i.port_select].io_dir);
        end else if (cfg[cpu_ctl_i.port_select].mode == MODE_OUT) begin
            rd_data = out_reg[cpu_ctl_i.port_select];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst) begin
            cpu_data_o <= 8'h00;
            cpu_data_oe_o <= 1'b0;
            ack_hold <= 1'b0;
        end else begin
            ack_hold <= ack_act && (ack_hold || (ack_start && grant));
            if (ack_start && grant) cpu_data_o <= cfg[grant_b].vector;
            else if (rd_act) cpu_data_o <= rd_data;
            cpu_data_oe_o <= rd_act
                || (ack_act && (ack_hold || (ack_start && grant)));
        end
    end

    // -------------------------------------------------
    // Checks
    // -------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst);

    sequence s_b_out_write;
        data_wr[1] && role_out[1];
    endsequence
    sequence s_a_read_done;
        rd_end && rd_port == 1'b0 && cfg[0].mode == MODE_IN;
    endsequence

    a_out_ready_set: assert property (
        s_b_out_write ##1 role_out[1] |-> port_b_ready_o)
        else $error("ready not raised after output write");
    a_strobe_clears: assert property (
        stb_rise[1] && role_out[1] && !load_out[1] |=> !port_b_ready_o)
        else $error("ready held after output strobe");
    a_input_full: assert property (
        stb_rise[0] && cfg[0].mode == MODE_IN ##1 cfg[0].mode == MODE_IN
        |-> !port_a_ready_o)
        else $error("input ready not dropped");
    a_read_refill: assert property (
        (s_a_read_done and !stb_rise[0]) ##1 cfg[0].mode == MODE_IN
        |-> port_a_ready_o)
        else $error("ready not restored after read");
    a_chain_block: assert property (
        !priority_in_i |=> !priority_out_o)
        else $error("priority passed without input");
    a_service_holds: assert property (
        srv != 2'b00 |=> !priority_out_o)
        else $error("chain open while in service");
    a_bidir_drive: assert property (
        a_bidir && $past(a_bidir) && port_a_oe_o != 8'h00
        |-> $past(!port_a_strobe_n_i))
        else $error("port A driven without strobe");
    a_bit_no_ready: assert property (
        (cfg[1].mode == MODE_BIT && !a_bidir) [*2] |-> !port_b_ready_o)
        else $error("ready active in bit mode");
    a_vector_even: assert property (
        ack_start && grant |=> cpu_data_oe_o && !cpu_data_o[0])
        else $error("vector odd or not driven");
    a_arm_wait: assert property (
        cmd_wr[0] ##1 cpu_ctl_i.cycle_one_n [*2] |-> !armed[0])
        else $error("armed before cycle one");

endmodule : parallel_port_handshake_irq

// ### parallel_port_pkg.sv
// Shared types and constants for the two-port handshake parallel port
package parallel_port_pkg;

    typedef enum logic [1:0] {
        MODE_OUT = 2'b00,
        MODE_IN = 2'b01,
        MODE_BIDIR = 2'b10,
        MODE_BIT = 2'b11
    } port_mode_t;

    typedef enum logic [1:0] {
        NEXT_CMD = 2'b00,
        NEXT_DIR = 2'b01,
        NEXT_MASK = 2'b10
    } next_word_t;

    typedef struct packed {
        port_mode_t mode;
        logic [7:0] vector;
        logic [7:0] io_dir;
        logic [7:0] mask;
        logic int_en;
        logic and_mode;
        logic active_high;
        next_word_t next_word;
    } port_cfg_t;

    typedef struct packed {
        logic chip_select_n;
        logic io_request_n;
        logic read_strobe_n;
        logic cycle_one_n;
        logic port_select;
        logic control_data_select;
    } cpu_ctl_t;

    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int CLK_PERIOD_NS = 20;
    localparam int RESET_HOLD_CYCLES = 2;
    localparam logic [3:0] CW_MODE = 4'hF;
    localparam logic [3:0] CW_INT_CTRL = 4'h7;
    localparam logic [3:0] CW_INT_EN = 4'h3;
    localparam int CW_IE_BIT = 7;
    localparam int CW_AND_BIT = 6;
    localparam int CW_HIGH_BIT = 5;
    localparam int CW_MASK_BIT = 4;
    localparam logic [7:0] OPC_PREFIX = 8'hED;
    localparam logic [7:0] OPC_RETURN = 8'h4D;
    localparam port_cfg_t CFG_RESET = '{
        mode: MODE_IN, vector: 8'h00, io_dir: 8'hFF, mask: 8'hFF,
        int_en: 1'b0, and_mode: 1'b0, active_high: 1'b0,
        next_word: NEXT_CMD};

endpackage : parallel_port_pkg

// ### periph_model.sv
// Peripheral model answering a ready/strobe handshake on one port
module periph_model (
    input wire logic sys_clk_i,
    input wire logic en_i,
    input wire logic ready_i,
    input wire logic [7:0] data_i,
    output logic strobe_n_o,
    output logic [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] st;
    logic [1:0] cnt;
    initial begin
        strobe_n_o = 1'b1;
        data_o = ~data_i;
        st = 2'd0;
        cnt = 2'd0;
    end
    // Data is only valid while strobe is low; otherwise inverted
    always @(posedge sys_clk_i) begin
        case (st)
            2'd0: if (en_i && ready_i) begin
                st <= 2'd1;
                cnt <= 2'd3;
            end
            2'd1: begin
                strobe_n_o <= 1'b0;
                data_o <= data_i;
                cnt <= cnt - 2'd1;
                if (cnt == 2'd1) st <= 2'd2;
            end
            default: begin
                strobe_n_o <= 1'b1;
                data_o <= ~data_i;
                if (!ready_i) st <= 2'd0;
            end
        endcase
    end
endmodule : periph_model

// ### parallel_port_handshake_irq_tb_top.sv
// Self-checking testbench for the handshake parallel port
module parallel_port_handshake_irq_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import parallel_port_pkg::*;
    logic sys_clk_i, reset_n_i, priority_in_i, b_stb_n, a_en, a_stb_n;
    logic a_rdy, b_rdy, wr_rdy, prio_out, oe;
    logic [7:0] wdata, a_pins, a_out, a_oe, b_out, b_oe, rdata, cpu_q;
    cpu_ctl_t ctl;
    int err_count, checked;

    parallel_port_handshake_irq u_parallel_port_handshake_irq (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .cpu_ctl_i(ctl),
        .cpu_data_i(wdata), .cpu_data_o(cpu_q), .cpu_data_oe_o(oe),
        .cpu_write_ready_o(wr_rdy), .priority_in_i(priority_in_i),
        .priority_out_o(prio_out), .irq_n_i(1'b1), .irq_n_o(),
        .irq_oe_o(), .port_a_i(a_pins), .port_a_o(a_out),
        .port_a_oe_o(a_oe), .port_a_strobe_n_i(a_stb_n),
        .port_a_ready_o(a_rdy), .port_b_i(8'h00), .port_b_o(b_out),
        .port_b_oe_o(b_oe), .port_b_strobe_n_i(b_stb_n),
        .port_b_ready_o(b_rdy));
    periph_model u_periph_model (.sys_clk_i(sys_clk_i), .en_i(a_en),
        .ready_i(a_rdy), .data_i(8'hA5), .strobe_n_o(a_stb_n),
        .data_o(a_pins));

    // -------------------------------------------------
    // Bus cycles and checking
    // -------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s exp %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic cpu_io(input logic ps, cd, rd_n, input logic [7:0] d);
        @(posedge sys_clk_i);
        ctl <= {2'b00, rd_n, 1'b1, ps, cd};
        wdata <= d;
        @(posedge sys_clk_i);
        if (!rd_n) begin
            repeat (2) @(posedge sys_clk_i);
            @(negedge sys_clk_i);
            rdata = cpu_q;
            chk("read oe", {7'd0, oe}, 8'h01);
            @(posedge sys_clk_i);
        end
        ctl <= 6'b111100;
        @(posedge sys_clk_i);
    endtask : cpu_io

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
    endtask : settle

    // -------------------------------------------------
    // Scenarios
    // -------------------------------------------------
    task automatic t_chain();
        @(posedge sys_clk_i);
        priority_in_i <= 1'b0;
        settle(3);
        chk("chain low", {7'd0, prio_out}, 8'h00);
        @(posedge sys_clk_i);
        priority_in_i <= 1'b1;
        settle(3);
        chk("chain high", {7'd0, prio_out}, 8'h01);
    endtask : t_chain

    task automatic t_input();
        @(posedge sys_clk_i);
        a_en <= 1'b1;
        for (int i = 0; i < 100 && a_rdy !== 1'b0; i++) settle(1);
        chk("a full", {7'd0, a_rdy}, 8'h00);
        @(posedge sys_clk_i);
        a_en <= 1'b0;
        cpu_io(1'b0, 1'b0, 1'b0, 8'h00);
        chk("a read", rdata, 8'hA5);
        settle(2);
        chk("a refill", {7'd0, a_rdy}, 8'h01);
    endtask : t_input

    task automatic t_out_b();
        cpu_io(1'b1, 1'b1, 1'b1, 8'h0F);
        cpu_io(1'b1, 1'b0, 1'b1, 8'h3C);
        settle(2);
        chk("b data", b_out, 8'h3C);
        chk("b oe", b_oe, 8'hFF);
        @(posedge sys_clk_i);
        b_stb_n <= 1'b0;
        settle(3);
        chk("b hold", {7'd0, b_rdy}, 8'h01);
        @(posedge sys_clk_i);
        b_stb_n <= 1'b1;
        settle(3);
        chk("b taken", {7'd0, b_rdy}, 8'h00);
    endtask : t_out_b

    task automatic t_cycle_reset();
        @(posedge sys_clk_i);
        ctl <= 6'b111000;
        settle(3);
        @(posedge sys_clk_i);
        ctl <= 6'b111100;
        settle(3);
        chk("b oe reset", b_oe, 8'h00);
        chk("b ready reset", {7'd0, b_rdy}, 8'h01);
    endtask : t_cycle_reset

    task automatic t_fifo_a();
        cpu_io(1'b0, 1'b1, 1'b1, 8'h0F);
        for (int i = 0; i < 10; i++) cpu_io(1'b0, 1'b0, 1'b1, 8'h10 + 8'(i));
        settle(2);
        chk("fifo full", {7'd0, wr_rdy}, 8'h00);
        chk("a first", a_out, 8'h10);
        @(posedge sys_clk_i);
        a_en <= 1'b1;
        settle(400);
        chk("a last", a_out, 8'h18);
        chk("a idle", {7'd0, a_rdy}, 8'h00);
        chk("fifo empty", {7'd0, wr_rdy}, 8'h01);
    endtask : t_fifo_a

    task automatic t_bidir();
        @(posedge sys_clk_i);
        a_en <= 1'b0;
        cpu_io(1'b1, 1'b1, 1'b1, 8'hFF);
        cpu_io(1'b1, 1'b1, 1'b1, 8'hFF);
        cpu_io(1'b1, 1'b1, 1'b1, 8'h17);
        cpu_io(1'b1, 1'b1, 1'b1, 8'hFF);
        cpu_io(1'b0, 1'b1, 1'b1, 8'h8F);
        cpu_io(1'b0, 1'b0, 1'b1, 8'h5A);
        settle(2);
        chk("bidir a rdy", {7'd0, a_rdy}, 8'h01);
        chk("bidir a oe", a_oe, 8'h00);
        chk("bidir b rdy", {7'd0, b_rdy}, 8'h01);
        @(posedge sys_clk_i);
        a_en <= 1'b1;
        settle(12);
        chk("bidir a taken", {7'd0, a_rdy}, 8'h00);
        chk("bidir a data", a_out, 8'h5A);
        @(posedge sys_clk_i);
        b_stb_n <= 1'b0;
        settle(2);
        @(posedge sys_clk_i);
        b_stb_n <= 1'b1;
        settle(2);
        chk("bidir b full", {7'd0, b_rdy}, 8'h00);
        cpu_io(1'b0, 1'b0, 1'b0, 8'h00);
        chk("bidir read", rdata, 8'h5A);
        settle(2);
        chk("bidir b refill", {7'd0, b_rdy}, 8'h01);
    endtask : t_bidir

    task automatic wrap_up();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    initial begin
        sys_clk_i = 1'b0;
        forever #10 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        #(20 * 5000);
        err_count++;
        wrap_up();
    end

    initial begin
        reset_n_i = 1'b0;
        priority_in_i = 1'b1;
        b_stb_n = 1'b1;
        a_en = 1'b0;
        wdata = 8'h00;
        ctl = 6'b111100;
        err_count = 0;
        checked = 0;
        repeat (16) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        settle(2);
        chk("a ready reset", {7'd0, a_rdy}, 8'h01);
        t_chain();
        t_input();
        t_out_b();
        t_cycle_reset();
        t_fifo_a();
        t_bidir();
        wrap_up();
    end
endmodule : parallel_port_handshake_irq_tb_top
